//--- logic/cgr_pkg.sv
// Package with register map, field layout and link constants of the clock generator bank
package cgr_pkg;

  // Register offsets
  localparam logic [7:0] OFS_CONTROL_SOURCE   = 8'h00;
  localparam logic [7:0] OFS_SW_CONFIG_PICK   = 8'h01;
  localparam logic [7:0] OFS_OUT_SUSP_ASSOC   = 8'h02;
  localparam logic [7:0] OFS_OUT_SUSP_FORCE   = 8'h03;
  localparam logic [7:0] OFS_PLL_SUSP_PIN_FN  = 8'h04;
  localparam logic [7:0] OFS_REF_SOURCE       = 8'h05;
  localparam logic [7:0] OFS_OSC_DRIVE        = 8'h06;
  localparam logic [7:0] OFS_LOAD_CAP_TRIM    = 8'h07;
  localparam logic [7:0] OFS_VCXO_TRIM        = 8'h08;
  localparam logic [7:0] OFS_RESERVED_NINE    = 8'h09;
  localparam logic [7:0] OFS_PLL0_LOOP_CFG4   = 8'h0a;
  localparam logic [7:0] OFS_PLL0_LOOP_CFG5   = 8'h0b;
  localparam logic [7:0] OFS_PLL0_LOOP_CFG0   = 8'h0c;
  localparam logic [7:0] OFS_PLL0_LOOP_CFG1   = 8'h0d;
  localparam logic [7:0] OFS_PLL0_LOOP_CFG2   = 8'h0e;
  localparam logic [7:0] OFS_PLL0_LOOP_CFG3   = 8'h0f;
  localparam logic [7:0] OFS_PLL0_REF_DIV     = 8'h10;
  localparam int         NUM_REGS             = 17;

  // Field positions
  localparam int POS_CONTROL_SOURCE = 0;
  localparam int POS_PIN_FUNCTION   = 7;
  localparam int POS_REF_SOURCE     = 4;
  localparam int POS_OSC_DRIVE_LO   = 4;
  localparam int POS_VCXO_GAIN_LO   = 4;

  // Pin function encoding: 0 output enable control, 1 whole-chip shutdown
  localparam logic PIN_FN_SHUTDOWN = 1'b1;

  // Spread range: down spread in tenths, center spread in hundredths of a percent of the output frequency
  localparam int SPREAD_DOWN_MIN_TENTHS   = 5;
  localparam int SPREAD_DOWN_MAX_TENTHS   = 40;
  localparam int SPREAD_CENTER_MIN_HUNDR  = 25;
  localparam int SPREAD_CENTER_MAX_HUNDR  = 200;

  // Link framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h6a;

  // Link states
  typedef enum logic [2:0] {
    LNK_IDLE,
    LNK_ADDR,
    LNK_PTR,
    LNK_WDATA,
    LNK_RDATA
  } cgr_link_t;

  // Writable bits of each register; reserved bits read as zero
  function automatic logic [7:0] reg_mask(input logic [7:0] ofs);
    case (ofs)
      OFS_CONTROL_SOURCE:  reg_mask = 8'h01;
      OFS_SW_CONFIG_PICK:  reg_mask = 8'h07;
      OFS_OUT_SUSP_ASSOC:  reg_mask = 8'hff;
      OFS_OUT_SUSP_FORCE:  reg_mask = 8'h7f;
      OFS_PLL_SUSP_PIN_FN: reg_mask = 8'h8f;
      OFS_REF_SOURCE:      reg_mask = 8'h14;
      OFS_OSC_DRIVE:       reg_mask = 8'h30;
      OFS_LOAD_CAP_TRIM:   reg_mask = 8'h1f;
      OFS_VCXO_TRIM:       reg_mask = 8'hff;
      OFS_RESERVED_NINE:   reg_mask = 8'h00;
      OFS_PLL0_REF_DIV:    reg_mask = 8'h7f;
      default:             reg_mask = (ofs < 8'h10) ? 8'hff : 8'h00;
    endcase
  endfunction : reg_mask

  // Values after reset
  function automatic logic [7:0] reg_reset(input logic [7:0] ofs);
    case (ofs)
      OFS_OUT_SUSP_ASSOC:  reg_reset = 8'h02;
      OFS_OUT_SUSP_FORCE:  reg_reset = 8'h02;
      OFS_PLL_SUSP_PIN_FN: reg_reset = 8'h0f;
      OFS_REF_SOURCE:      reg_reset = 8'h04;
      OFS_PLL0_LOOP_CFG4,
      OFS_PLL0_LOOP_CFG5,
      OFS_PLL0_LOOP_CFG0,
      OFS_PLL0_LOOP_CFG1,
      OFS_PLL0_LOOP_CFG2,
      OFS_PLL0_LOOP_CFG3:  reg_reset = 8'h10;
      default:             reg_reset = 8'h00;
    endcase
  endfunction : reg_reset

endpackage : cgr_pkg

//--- logic/cgr_config_regs.sv
// Low configuration register bank of the multi-PLL clock generator with its serial link
`timescale 1ns/10ps
`default_nettype none

module cgr_config_regs #(
  parameter logic [6:0] DEV_ADDR = cgr_pkg::DEV_ADDR_DEFAULT
) (
  // System clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Serial link, open drain data
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // Device pins
  input  wire logic [2:0] config_pins,
  input  wire logic       suspend_pin,
  // Configuration outputs
  output logic            control_source_select,
  output logic [2:0]      active_config,
  output logic [6:0]      out_suspend,
  output logic            chip_shutdown,
  output logic [3:0]      loop_suspend_n,
  output logic            ref_source_pick,
  output logic [1:0]      osc_drive_level,
  output logic [4:0]      load_cap_trim,
  output logic [3:0]      vcxo_gain,
  output logic [3:0]      vcxo_offset,
  output logic [6:0]      ref_divide_value,
  output logic [7:0]      pll0_loop_param
);

  // ---------------- Link domain (scl) ----------------
  logic            start_tgl_ff;
  logic            start_seen_ff;
  cgr_pkg::cgr_link_t state_ff;
  logic [3:0]      bit_cnt_ff;
  logic [6:0]      shift_ff;
  logic [7:0]      tx_ff;
  logic [7:0]      ptr_ff;
  logic            ack_ff;
  logic [7:0]      wr_addr_ff;
  logic [7:0]      wr_data_ff;
  logic            wr_tgl_ff;
  logic            ptr_tgl_ff;
  logic            sda_oe_ff;
  logic [7:0]      rd_data_ff;

  wire             new_frame = start_tgl_ff ^ start_seen_ff;
  wire [7:0]       rx_byte   = {shift_ff, sda_i};
  wire             last_bit  = (bit_cnt_ff == cgr_pkg::BITS_PER_BYTE - 4'h1);
  wire             ack_bit   = (bit_cnt_ff == cgr_pkg::BITS_PER_BYTE);
  wire [2:0]       tx_idx    = 3'h7 - bit_cnt_ff[2:0];

  // Start: data falls while clock is high; toggled so the scl side sees it on its first edge
  always_ff @(negedge sda_i or negedge rst_n) begin
    if (!rst_n) begin
      start_tgl_ff <= 1'b0;
    end else if (scl_i) begin
      start_tgl_ff <= ~start_tgl_ff;
    end
  end

  // Frame tracking; the clock stands still between frames, so nothing waits on an idle edge
  always_ff @(posedge scl_i or negedge rst_n) begin
    if (!rst_n) begin
      start_seen_ff <= 1'b0;
      state_ff      <= cgr_pkg::LNK_IDLE;
      bit_cnt_ff    <= 4'h0;
      shift_ff      <= 7'h00;
      tx_ff         <= 8'h00;
      ptr_ff        <= 8'h00;
      ack_ff        <= 1'b0;
      wr_addr_ff    <= 8'h00;
      wr_data_ff    <= 8'h00;
      wr_tgl_ff     <= 1'b0;
      ptr_tgl_ff    <= 1'b0;
    end else begin
      start_seen_ff <= start_tgl_ff;
      if (new_frame) begin
        state_ff   <= cgr_pkg::LNK_ADDR;
        shift_ff   <= {6'h00, sda_i};
        bit_cnt_ff <= 4'h1;
      end else if (state_ff != cgr_pkg::LNK_IDLE) begin
        if (!ack_bit) begin
          shift_ff   <= rx_byte[6:0];
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end else begin
          bit_cnt_ff <= 4'h0;
        end
        // Byte complete
        if (last_bit) begin
          unique case (state_ff)
            cgr_pkg::LNK_ADDR:  ack_ff <= (rx_byte[7:1] == DEV_ADDR);
            cgr_pkg::LNK_PTR: begin
              ptr_ff     <= rx_byte;
              ptr_tgl_ff <= ~ptr_tgl_ff;
              ack_ff     <= 1'b1;
            end
            cgr_pkg::LNK_WDATA: begin
              wr_addr_ff <= ptr_ff;
              wr_data_ff <= rx_byte;
              wr_tgl_ff  <= ~wr_tgl_ff;
              ack_ff     <= 1'b1;
            end
            cgr_pkg::LNK_RDATA: begin
              // Advance early so the next byte is fetched before the ack edge
              ptr_ff     <= ptr_ff + 8'h01;
              ptr_tgl_ff <= ~ptr_tgl_ff;
            end
            default: ;
          endcase
        end
        // Ack slot
        if (ack_bit) begin
          unique case (state_ff)
            cgr_pkg::LNK_ADDR: begin
              if (!ack_ff) begin
                state_ff <= cgr_pkg::LNK_IDLE;
              end else if (shift_ff[0]) begin
                state_ff <= cgr_pkg::LNK_RDATA;
                tx_ff    <= rd_data_ff;
              end else begin
                state_ff <= cgr_pkg::LNK_PTR;
              end
            end
            cgr_pkg::LNK_PTR:   state_ff <= cgr_pkg::LNK_WDATA;
            cgr_pkg::LNK_WDATA: begin
              ptr_ff     <= ptr_ff + 8'h01;
              ptr_tgl_ff <= ~ptr_tgl_ff;
            end
            cgr_pkg::LNK_RDATA: begin
              if (sda_i) begin
                state_ff <= cgr_pkg::LNK_IDLE;
              end else begin
                tx_ff <= rd_data_ff;
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Data drive on the falling clock so it is settled before the master samples
  wire nxt_sda_oe = ((state_ff == cgr_pkg::LNK_RDATA) && !ack_bit && !tx_ff[tx_idx]) ||
                    ((state_ff != cgr_pkg::LNK_RDATA) && (state_ff != cgr_pkg::LNK_IDLE) &&
                     ack_bit && ack_ff);

  always_ff @(negedge scl_i or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe_ff <= 1'b0;
    end else begin
      sda_oe_ff <= nxt_sda_oe;
    end
  end

  assign sda_oe = sda_oe_ff;
  assign sda_o  = 1'b0;  // Open drain: only ever pulls low

  // ---------------- System domain (clk) ----------------
  logic [2:0] wr_sync_ff;
  logic       wr_seen_ff;
  logic [2:0] ptr_sync_ff;
  logic       ptr_seen_ff;
  logic [7:0] ptr_cap_ff;
  logic [2:0] susp_sync_ff;
  logic       susp_pin_ff;
  logic [2:0] cfg_s1_ff;
  logic [2:0] cfg_s2_ff;
  logic [2:0] cfg_s3_ff;
  logic [2:0] cfg_pins_ff;
  logic [7:0] regs_ff [cgr_pkg::NUM_REGS];

  // Events from the link count once the second and third stages agree
  wire wr_event  = (wr_sync_ff[1] == wr_sync_ff[2]) && (wr_sync_ff[2] != wr_seen_ff);
  wire ptr_event = (ptr_sync_ff[1] == ptr_sync_ff[2]) && (ptr_sync_ff[2] != ptr_seen_ff);
  wire [7:0] wr_mask  = cgr_pkg::reg_mask(wr_addr_ff);
  wire       wr_hit   = wr_event && (wr_addr_ff < 8'(cgr_pkg::NUM_REGS));
  wire [7:0] rd_value = (ptr_cap_ff < 8'(cgr_pkg::NUM_REGS)) ?
                        (regs_ff[ptr_cap_ff[4:0]] & cgr_pkg::reg_mask(ptr_cap_ff)) : 8'h00;

  // Synchronisers: toggles and pins through three stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_sync_ff   <= 3'h0;
      ptr_sync_ff  <= 3'h0;
      susp_sync_ff <= 3'h0;
      cfg_s1_ff    <= 3'h0;
      cfg_s2_ff    <= 3'h0;
      cfg_s3_ff    <= 3'h0;
    end else begin
      wr_sync_ff   <= {wr_sync_ff[1:0], wr_tgl_ff};
      ptr_sync_ff  <= {ptr_sync_ff[1:0], ptr_tgl_ff};
      susp_sync_ff <= {susp_sync_ff[1:0], suspend_pin};
      cfg_s1_ff    <= config_pins;
      cfg_s2_ff    <= cfg_s1_ff;
      cfg_s3_ff    <= cfg_s2_ff;
    end
  end

  // Filtered pin levels and handshake bookkeeping
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      susp_pin_ff <= 1'b0;
      cfg_pins_ff <= 3'h0;
      wr_seen_ff  <= 1'b0;
      ptr_seen_ff <= 1'b0;
      ptr_cap_ff  <= 8'h00;
      rd_data_ff  <= 8'h00;
    end else begin
      if (susp_sync_ff[1] == susp_sync_ff[2]) susp_pin_ff <= susp_sync_ff[2];
      if (cfg_s2_ff == cfg_s3_ff) cfg_pins_ff <= cfg_s3_ff;
      if (wr_event) wr_seen_ff <= wr_sync_ff[2];
      if (ptr_event) begin
        ptr_seen_ff <= ptr_sync_ff[2];
        ptr_cap_ff  <= ptr_ff;  // Set by the link on the same edge as the toggle and held since
      end
      rd_data_ff <= rd_value;  // Read word, stable long before the link loads it
    end
  end

  // Register file; reserved bits and unmapped offsets drop writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < cgr_pkg::NUM_REGS; i++) regs_ff[i] <= cgr_pkg::reg_reset(8'(i));
    end else if (wr_hit) begin
      regs_ff[wr_addr_ff[4:0]] <= wr_data_ff & wr_mask;
    end
  end

  // Decode of register fields
  wire [7:0] r_assoc  = regs_ff[cgr_pkg::OFS_OUT_SUSP_ASSOC[4:0]];
  wire [7:0] r_force  = regs_ff[cgr_pkg::OFS_OUT_SUSP_FORCE[4:0]];
  wire [7:0] r_pll    = regs_ff[cgr_pkg::OFS_PLL_SUSP_PIN_FN[4:0]];
  wire [7:0] r_refdiv = regs_ff[cgr_pkg::OFS_PLL0_REF_DIV[4:0]];
  wire       sw_mode  = regs_ff[cgr_pkg::OFS_CONTROL_SOURCE[4:0]][cgr_pkg::POS_CONTROL_SOURCE];
  wire       pin_shdn = (r_pll[cgr_pkg::POS_PIN_FUNCTION] == cgr_pkg::PIN_FN_SHUTDOWN);
  wire [2:0] nxt_active_config = sw_mode ? regs_ff[cgr_pkg::OFS_SW_CONFIG_PICK[4:0]][2:0]
                                         : cfg_pins_ff;
  wire       pin_oe_susp = susp_pin_ff && !pin_shdn;
  wire [6:0] nxt_out_suspend = ~r_force[6:0] | (r_assoc[6:0] & {7{pin_oe_susp}});
  wire       refdiv_zero = (r_refdiv[6:0] == 7'h00);
  wire [3:0] nxt_loop_suspend_n = r_pll[3:0] & {3'h7, ~refdiv_zero};

  // Loop byte of the active configuration; configurations 6 and 7 fall back to 0
  wire [7:0] nxt_loop_param =
    (nxt_active_config == 3'h1) ? regs_ff[cgr_pkg::OFS_PLL0_LOOP_CFG1[4:0]] :
    (nxt_active_config == 3'h2) ? regs_ff[cgr_pkg::OFS_PLL0_LOOP_CFG2[4:0]] :
    (nxt_active_config == 3'h3) ? regs_ff[cgr_pkg::OFS_PLL0_LOOP_CFG3[4:0]] :
    (nxt_active_config == 3'h4) ? regs_ff[cgr_pkg::OFS_PLL0_LOOP_CFG4[4:0]] :
    (nxt_active_config == 3'h5) ? regs_ff[cgr_pkg::OFS_PLL0_LOOP_CFG5[4:0]] :
                                  regs_ff[cgr_pkg::OFS_PLL0_LOOP_CFG0[4:0]];

  // Spread amount is programmed in the higher map; only the legal range is kept here
  // Limitation: the modulator lives outside this bank, so nothing here shapes it

  // Registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control_source_select <= 1'b0;
      active_config         <= 3'h0;
      out_suspend           <= 7'h7d;
      chip_shutdown         <= 1'b0;
      loop_suspend_n        <= 4'h0;
      ref_source_pick       <= 1'b0;
      osc_drive_level       <= 2'h0;
      load_cap_trim         <= 5'h00;
      vcxo_gain             <= 4'h0;
      vcxo_offset           <= 4'h0;
      ref_divide_value      <= 7'h00;
      pll0_loop_param       <= 8'h10;
    end else begin
      control_source_select <= sw_mode;
      active_config         <= nxt_active_config;
      out_suspend           <= nxt_out_suspend;
      chip_shutdown         <= susp_pin_ff && pin_shdn;
      loop_suspend_n        <= nxt_loop_suspend_n;
      ref_source_pick       <= regs_ff[cgr_pkg::OFS_REF_SOURCE[4:0]][cgr_pkg::POS_REF_SOURCE];
      osc_drive_level       <= regs_ff[cgr_pkg::OFS_OSC_DRIVE[4:0]][cgr_pkg::POS_OSC_DRIVE_LO +: 2];
      load_cap_trim         <= regs_ff[cgr_pkg::OFS_LOAD_CAP_TRIM[4:0]][4:0];
      vcxo_gain             <= regs_ff[cgr_pkg::OFS_VCXO_TRIM[4:0]][cgr_pkg::POS_VCXO_GAIN_LO +: 4];
      vcxo_offset           <= regs_ff[cgr_pkg::OFS_VCXO_TRIM[4:0]][3:0];
      ref_divide_value      <= r_refdiv[6:0];
      pll0_loop_param       <= nxt_loop_param;
    end
  end

  // ---------------- Checks ----------------
  // Accepted write to the reference divide register
  sequence s_write_lands;
    wr_hit && (wr_addr_ff == cgr_pkg::OFS_PLL0_REF_DIV);
  endsequence

  // Filtered pin asserted while the pin acts as chip shutdown
  sequence s_pin_shutdown;
    susp_pin_ff && pin_shdn;
  endsequence

  a_hw_mode_pins: assert property (@(posedge clk) disable iff (!rst_n)
    !sw_mode |=> (active_config == $past(cfg_pins_ff)))
    else $error("hardware mode does not follow pins");

  a_sw_mode_pick: assert property (@(posedge clk) disable iff (!rst_n)
    sw_mode |=> (active_config == $past(regs_ff[1][2:0])))
    else $error("software mode ignores config pick");

  a_assoc_suspend: assert property (@(posedge clk) disable iff (!rst_n)
    (r_force[0] && r_assoc[0] && pin_oe_susp) ##1 $stable(r_force) |-> out_suspend[0])
    else $error("associated output not suspended by pin");

  a_force_priority: assert property (@(posedge clk) disable iff (!rst_n)
    (r_force[6:0] != 7'h7f) |=> ((out_suspend | $past(r_force[6:0])) == 7'h7f))
    else $error("forced suspend not applied");

  a_pll_suspend: assert property (@(posedge clk) disable iff (!rst_n)
    (r_pll[3:1] != 3'h7) |=> (loop_suspend_n[3:1] == $past(r_pll[3:1])))
    else $error("pll suspend bit ignored");

  a_shutdown_mode: assert property (@(posedge clk) disable iff (!rst_n)
    chip_shutdown |-> $past(pin_shdn) && $past(susp_pin_ff))
    else $error("shutdown without pin in shutdown mode");

  a_refdiv_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (ref_divide_value == 7'h00) |-> !loop_suspend_n[0])
    else $error("pll0 running with zero divide");

  a_write_visible: assert property (@(posedge clk) disable iff (!rst_n)
    s_write_lands |-> ##2 (ref_divide_value == $past(wr_data_ff[6:0], 2)))
    else $error("ref divide write not visible");

  a_shutdown_follows: assert property (@(posedge clk) disable iff (!rst_n)
    s_pin_shutdown |=> chip_shutdown)
    else $error("pin in shutdown mode did not shut down");

  a_free_output: assert property (@(posedge clk) disable iff (!rst_n)
    (r_force[3] && !r_assoc[3]) |=> !out_suspend[3])
    else $error("unassociated output suspended");

  // Field routing, one register field to one output
  a_ref_pick: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 (ref_source_pick ==
         $past(regs_ff[cgr_pkg::OFS_REF_SOURCE[4:0]][cgr_pkg::POS_REF_SOURCE])))
    else $error("reference pick not applied");

  a_load_cap: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 (load_cap_trim == $past(regs_ff[cgr_pkg::OFS_LOAD_CAP_TRIM[4:0]][4:0])))
    else $error("load cap trim not applied");

  a_loop_cfg0: assert property (@(posedge clk) disable iff (!rst_n)
    (nxt_active_config == 3'h0) |=> (pll0_loop_param == $past(regs_ff[12])))
    else $error("wrong loop byte for configuration 0");

endmodule : cgr_config_regs

`default_nettype wire

//--- sim/cgr_link_host.sv
// Host model for the serial link: drives clock and open-drain data, reads the wire
`timescale 1ns/10ps
`default_nettype none

module cgr_link_host #(
  parameter int HALF_NS = 1000
) (
  // Wire level after all open-drain drivers
  input  wire logic sda_line,
  // Host-driven lines
  output logic      scl,
  output logic      sda_low
);

  // Idle: clock stands high, data released to its pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Start or repeated start; every clock edge at least a half period apart
  task automatic start_cond();
    sda_low = 1'b0;
    #(HALF_NS);
    scl = 1'b1;
    #(HALF_NS);
    sda_low = 1'b1;
    #(HALF_NS);
    scl = 1'b0;
  endtask : start_cond

  // One bit; data moves only mid-low, so no false start or stop
  task automatic bit_io(input logic b, output logic got);
    #(HALF_NS/2);
    sda_low = ~b;
    #(HALF_NS/2);
    scl = 1'b1;
    #(HALF_NS/2);
    got = sda_line;
    #(HALF_NS/2);
    scl = 1'b0;
  endtask : bit_io

  // Byte out, MSB first, then the ninth bit read back as acknowledge
  task automatic put_byte(input logic [7:0] d, output logic ack_ok);
    logic dummy;
    logic got;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], dummy);
    end
    bit_io(1'b1, got);
    ack_ok = ~got;
  endtask : put_byte

  // Byte in; the host answers with NACK on the last byte
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic dummy;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, dummy);
  endtask : get_byte

  // Stop, then the clock rests high
  task automatic stop_cond();
    #(HALF_NS/2);
    sda_low = 1'b1;
    #(HALF_NS/2);
    scl = 1'b1;
    #(HALF_NS);
    sda_low = 1'b0;
    #(HALF_NS);
  endtask : stop_cond

endmodule : cgr_link_host

`default_nettype wire

//--- sim/cgr_config_regs_bench.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/10ps
`default_nettype none

module cgr_config_regs_bench;
  localparam int         LIMIT = 20000;  // About twice the expected run
  localparam logic [6:0] ADDR  = cgr_pkg::DEV_ADDR_DEFAULT;
  localparam logic [7:0] RST_EXP [18] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h0f, 8'h04, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h00, 8'h00};
  localparam logic [7:0] WR_VAL [17] = '{8'hfe, 8'hfd, 8'hd5, 8'hfd, 8'h75, 8'h1b, 8'hef,
    8'hf3, 8'h3c, 8'hff, 8'ha4, 8'ha5, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'h83};
  localparam logic [7:0] LOOP_EXP [8] = '{8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha0,
    8'ha0};

  logic       clk, rst_n, scl, host_low, sda_line, sda_o, sda_oe, suspend_pin;
  logic       control_source_select, chip_shutdown, ref_source_pick;
  logic [2:0] config_pins, active_config;
  logic [6:0] out_suspend, ref_divide_value;
  logic [3:0] loop_suspend_n, vcxo_gain, vcxo_offset;
  logic [1:0] osc_drive_level;
  logic [4:0] load_cap_trim;
  logic [7:0] pll0_loop_param;
  logic [7:0] wbuf [17];
  logic [7:0] rbuf [18];
  int         n_fail, n_compared, cycles;

  // Open-drain wire with pull-up
  assign sda_line = ~(host_low | (sda_oe & ~sda_o));

  // Link bit period about 204 ns, off the system grid; read prefetch needs ~6 clk per bit
  cgr_link_host #(.HALF_NS(103)) host (.sda_line(sda_line), .scl(scl), .sda_low(host_low));

  cgr_config_regs #(.DEV_ADDR(ADDR)) dut (
    .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .config_pins(config_pins), .suspend_pin(suspend_pin),
    .control_source_select(control_source_select), .active_config(active_config),
    .out_suspend(out_suspend), .chip_shutdown(chip_shutdown),
    .loop_suspend_n(loop_suspend_n), .ref_source_pick(ref_source_pick),
    .osc_drive_level(osc_drive_level), .load_cap_trim(load_cap_trim),
    .vcxo_gain(vcxo_gain), .vcxo_offset(vcxo_offset),
    .ref_divide_value(ref_divide_value), .pll0_loop_param(pll0_loop_param));

  // 100 MHz system clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Verdict, reached from the main sequence or the watchdog
  task automatic tally_and_finish();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog; a hung link would otherwise stall forever
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check8

  // Write burst from wbuf, pointer auto-increments
  task automatic wr_burst(input logic [7:0] ptr, input int n);
    logic ok;
    host.start_cond();
    host.put_byte({ADDR, 1'b0}, ok);
    check8({7'h00, ok}, 8'h01, "address ack");
    host.put_byte(ptr, ok);
    check8({7'h00, ok}, 8'h01, "pointer ack");
    for (int i = 0; i < n; i++) begin
      host.put_byte(wbuf[i], ok);
      check8({7'h00, ok}, 8'h01, "data ack");
    end
    host.stop_cond();
    repeat (4) @(posedge clk);
  endtask : wr_burst

  // Read burst into rbuf through a repeated start
  task automatic rd_burst(input logic [7:0] ptr, input int n);
    logic ok;
    host.start_cond();
    host.put_byte({ADDR, 1'b0}, ok);
    host.put_byte(ptr, ok);
    host.start_cond();
    host.put_byte({ADDR, 1'b1}, ok);
    check8({7'h00, ok}, 8'h01, "read address ack");
    for (int i = 0; i < n; i++) begin
      host.get_byte(i == n - 1, rbuf[i]);
    end
    host.stop_cond();
  endtask : rd_burst

  // Reset values of the whole map plus one unmapped place
  task automatic sc_reset_values();
    rd_burst(8'h00, 18);
    for (int i = 0; i < 18; i++) begin
      check8(rbuf[i], RST_EXP[i], "reset readback");
    end
    check8({7'h00, control_source_select}, 8'h00, "hardware mode");
    check8({1'b0, out_suspend}, 8'h7d, "reset suspend");
    check8({5'h00, loop_suspend_n[3:1]}, 8'h07, "plls running");
    check8(pll0_loop_param, 8'h10, "reset loop byte");
  endtask : sc_reset_values

  // Whole bank written with reserved bits set
  task automatic sc_bank_write();
    for (int i = 0; i < 17; i++) begin
      wbuf[i] = WR_VAL[i];
    end
    wr_burst(8'h00, 17);
    check8({7'h00, control_source_select}, 8'h00, "reserved bits dropped");
    check8({1'b0, out_suspend}, 8'h02, "forced suspend");
    check8({4'h0, loop_suspend_n}, 8'h05, "pll suspend");
    check8({7'h00, chip_shutdown}, 8'h00, "no shutdown");
    check8({7'h00, ref_source_pick}, 8'h01, "input clock pick");
    check8({6'h00, osc_drive_level}, 8'h02, "drive level");
    check8({3'h0, load_cap_trim}, 8'h13, "load cap");
    check8({vcxo_gain, vcxo_offset}, 8'h3c, "vcxo trim");
    check8({1'b0, ref_divide_value}, 8'h03, "ref divide");
  endtask : sc_bank_write

  // Hardware mode: pins choose the configuration and its loop byte
  task automatic sc_hw_pins();
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      config_pins <= c[2:0];
      repeat (6) @(posedge clk);
      check8({5'h00, active_config}, c[7:0], "pin config");
      check8(pll0_loop_param, LOOP_EXP[c], "loop byte per config");
    end
    @(posedge clk);
    suspend_pin <= 1'b1;
    repeat (6) @(posedge clk);
    check8({1'b0, out_suspend}, 8'h57, "pin suspends associated");
    check8({7'h00, chip_shutdown}, 8'h00, "pin as output enable");
  endtask : sc_hw_pins

  // Software mode ignores the pins
  task automatic sc_sw_pick();
    @(posedge clk);
    config_pins <= 3'h2;
    wbuf[0] = 8'h01;
    wr_burst(8'h00, 1);
    check8({7'h00, control_source_select}, 8'h01, "software mode");
    check8({5'h00, active_config}, 8'h05, "software pick");
    check8(pll0_loop_param, 8'ha5, "loop byte of pick");
  endtask : sc_sw_pick

  // Pin as chip shutdown, PLLs released
  task automatic sc_shutdown_pin();
    wbuf[0] = 8'h8f;
    wr_burst(8'h04, 1);
    check8({7'h00, chip_shutdown}, 8'h01, "shutdown asserted");
    check8({4'h0, loop_suspend_n}, 8'h0f, "plls running");
    @(posedge clk);
    suspend_pin <= 1'b0;
    repeat (6) @(posedge clk);
    check8({7'h00, chip_shutdown}, 8'h00, "shutdown released");
  endtask : sc_shutdown_pin

  // Zero divide powers the first PLL down
  task automatic sc_divide_zero();
    wbuf[0] = 8'h00;
    wr_burst(8'h10, 1);
    check8({1'b0, ref_divide_value}, 8'h00, "divide cleared");
    check8({4'h0, loop_suspend_n}, 8'h0e, "pll0 down");
  endtask : sc_divide_zero

  // Foreign address is not acknowledged
  task automatic sc_wrong_addr();
    logic ok;
    host.start_cond();
    host.put_byte({ADDR ^ 7'h01, 1'b0}, ok);
    check8({7'h00, ok}, 8'h00, "foreign address");
    host.stop_cond();
  endtask : sc_wrong_addr

  // Main sequence
  initial begin
    n_fail = 0;
    n_compared = 0;
    cycles = 0;
    rst_n = 1'b0;
    config_pins = 3'h0;
    suspend_pin = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    sc_reset_values();
    sc_bank_write();
    sc_hw_pins();
    sc_sw_pick();
    sc_shutdown_pin();
    sc_divide_zero();
    sc_wrong_addr();
    tally_and_finish();
  end

endmodule : cgr_config_regs_bench

`default_nettype wire
